//--- rtl/mcr_bank.sv
/*
 Modem configuration register bank with the datapath settings derived from it.
 Assumes the serial configuration port has already decoded host transfers
 into single-cycle register requests on i_mclk.
*/
// What this block does
// - Decimation is 8 times (4 plus bandwidth mantissa) times 2 to the bandwidth exponent.
// - The symbol rate is a float, 4-bit exponent and 9-bit mantissa with a hidden top one.
// - Symbol rate is (256 + mantissa) * 2^exponent / 2^28 times the reference clock.
// - Rate exponent is bits 3:0 of the first register, reset to 1100, read and write.
// - The stored symbol rate mantissa fills the second register, reset to 0x22, read and write.
// - Bit 7 of the third register at 0 keeps the DC blocking filter on and at 1 bypasses it.
// - Bits 6:4 of the third register pick the modulation, reset zero, some codes unassigned.
// - Bit 3 of the third register enables Manchester coding, reset to 0.
`timescale 1ns/1ps
`default_nettype none
`include "mcr_regs.svh"

module mcr_bank (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire mcr_pkg::mcr_req_s i_req,
	output logic [7:0] o_rdata,
	output logic o_rd_valid,
	output mcr_pkg::mcr_cfg_s o_cfg,
	output logic [8:0] o_decimation,
	output logic o_symbol_tick,
	output logic o_dc_block_enable,
	output logic o_mod_valid
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [8:0] mcr_decim(input logic [1:0] e, input logic [1:0] m);
		logic [8:0] base;
		base = {6'h00, `MCR_BW_MANT_OFFSET + {1'b0, m}};
		mcr_decim = base << (`MCR_BW_DIV_SHIFT + {2'h0, e});
	endfunction

	function automatic logic [23:0] mcr_rate_inc(input logic [3:0] e, input logic [7:0] m);
		logic [23:0] mant;
		mant = {15'h0000, `MCR_RATE_HIDDEN_ONE, m};
		mcr_rate_inc = mant << e;
	endfunction

	function automatic logic mcr_mod_ok(input logic [2:0] code);
		case (code)
			mcr_pkg::MCR_MOD_2FSK,
			mcr_pkg::MCR_MOD_GFSK,
			mcr_pkg::MCR_MOD_OOK,
			mcr_pkg::MCR_MOD_MSK: mcr_mod_ok = 1'b1;
			default: mcr_mod_ok = 1'b0;
		endcase
	endfunction

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	mcr_pkg::mcr_cfg_s cfg_reg;
	logic [`MCR_RATE_ACC_W-1:0] rate_acc_reg;
	logic [`MCR_RATE_ACC_W:0] rate_sum;
	logic wr_exp;
	logic wr_mant;
	logic wr_filt;

	assign wr_exp = i_req.wr_en && (i_req.addr == `MCR_OFS_BW_RATE_EXP);
	assign wr_mant = i_req.wr_en && (i_req.addr == `MCR_OFS_RATE_MANT);
	assign wr_filt = i_req.wr_en && (i_req.addr == `MCR_OFS_FILT_MOD);

	// One process owns cfg_reg, so the struct has a single driver
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			cfg_reg.bandwidth_exponent <= `MCR_RST_BW_EXP;
			cfg_reg.bandwidth_mantissa <= `MCR_RST_BW_MANT;
			cfg_reg.symbol_rate_exponent <= `MCR_RST_RATE_EXP;
			cfg_reg.symbol_rate_mantissa <= `MCR_RST_RATE_MANT;
			cfg_reg.dc_block_bypass <= `MCR_RST_DC_BYPASS;
			cfg_reg.modulation_select <= `MCR_RST_MOD;
			cfg_reg.manchester_enable <= `MCR_RST_MANCH;
		end else begin
			if (wr_exp) begin
				cfg_reg.bandwidth_exponent <= i_req.wdata[`MCR_BW_EXP_HI:`MCR_BW_EXP_LO];
				cfg_reg.bandwidth_mantissa <= i_req.wdata[`MCR_BW_MANT_HI:`MCR_BW_MANT_LO];
				cfg_reg.symbol_rate_exponent <= i_req.wdata[`MCR_RATE_EXP_HI:`MCR_RATE_EXP_LO];
			end
			if (wr_mant) begin
				cfg_reg.symbol_rate_mantissa <= i_req.wdata;
			end
			if (wr_filt) begin
				cfg_reg.dc_block_bypass <= i_req.wdata[`MCR_DC_BYPASS_BIT];
				cfg_reg.modulation_select <= i_req.wdata[`MCR_MOD_HI:`MCR_MOD_LO];
				cfg_reg.manchester_enable <= i_req.wdata[`MCR_MANCH_BIT];
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// readback of stored fields
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_req.rd_en;
			if (i_req.rd_en) begin
				case (i_req.addr)
					`MCR_OFS_BW_RATE_EXP: o_rdata <= {cfg_reg.bandwidth_exponent,
						cfg_reg.bandwidth_mantissa, cfg_reg.symbol_rate_exponent};
					`MCR_OFS_RATE_MANT: o_rdata <= cfg_reg.symbol_rate_mantissa;
					// Sync qualifier bits 2:0 live elsewhere; read as zero here
					`MCR_OFS_FILT_MOD: o_rdata <= {cfg_reg.dc_block_bypass,
						cfg_reg.modulation_select, cfg_reg.manchester_enable, 3'h0};
					default: o_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Datapath settings
	// ----------------------------------------
	assign o_cfg = cfg_reg;
	assign o_dc_block_enable = !cfg_reg.dc_block_bypass;
	assign o_mod_valid = mcr_mod_ok(cfg_reg.modulation_select);

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_decimation <= `MCR_RST_DECIM;
		end else begin
			o_decimation <= mcr_decim(cfg_reg.bandwidth_exponent, cfg_reg.bandwidth_mantissa);
		end
	end

	// rate accumulator, wraps at 2^28
	// Jitter of one clock per symbol is the price of a plain NCO
	assign rate_sum = {1'b0, rate_acc_reg}
		+ {5'h00, mcr_rate_inc(cfg_reg.symbol_rate_exponent, cfg_reg.symbol_rate_mantissa)};

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			rate_acc_reg <= '0;
			o_symbol_tick <= 1'b0;
		end else begin
			rate_acc_reg <= rate_sum[`MCR_RATE_ACC_W-1:0];
			o_symbol_tick <= rate_sum[`MCR_RATE_ACC_W];
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_decim;
		@(posedge i_mclk) disable iff (!i_resetn)
		##1 o_decimation == (9'h008 << $past(cfg_reg.bandwidth_exponent))
			* ({7'h00, $past(cfg_reg.bandwidth_mantissa)} + 9'h004);
	endproperty
	a_decim: assert property (p_decim) else $error("decimation ratio wrong");

	// Step of the accumulator must carry the hidden one above the stored mantissa
	property p_hidden_one;
		@(posedge i_mclk) disable iff (!i_resetn)
		i_resetn |=> (rate_acc_reg - $past(rate_acc_reg))
			== 28'((29'h100 + {21'h0, $past(cfg_reg.symbol_rate_mantissa)})
			<< $past(cfg_reg.symbol_rate_exponent));
	endproperty
	a_hidden_one: assert property (p_hidden_one) else $error("hidden mantissa bit lost");

	property p_rate_wrap;
		@(posedge i_mclk) disable iff (!i_resetn)
		##1 o_symbol_tick == (({1'b0, $past(rate_acc_reg)}
			+ ((29'h100 + {21'h0, $past(cfg_reg.symbol_rate_mantissa)})
			<< $past(cfg_reg.symbol_rate_exponent))) >= 29'h10000000);
	endproperty
	a_rate_wrap: assert property (p_rate_wrap) else $error("symbol tick mismatch");

	property p_exp_wr;
		@(posedge i_mclk) disable iff (!i_resetn)
		wr_exp |=> cfg_reg.symbol_rate_exponent == $past(i_req.wdata[3:0])
			&& o_cfg.bandwidth_exponent == $past(i_req.wdata[7:6]);
	endproperty
	a_exp_wr: assert property (p_exp_wr) else $error("exponent write lost");

	property p_mant_hold;
		@(posedge i_mclk) disable iff (!i_resetn)
		!wr_mant |=> $stable(cfg_reg.symbol_rate_mantissa);
	endproperty
	a_mant_hold: assert property (p_mant_hold) else $error("mantissa changed without write");

	property p_dc_filter;
		@(posedge i_mclk) disable iff (!i_resetn)
		wr_filt |=> o_dc_block_enable == !$past(i_req.wdata[7]);
	endproperty
	a_dc_filter: assert property (p_dc_filter) else $error("dc filter state wrong");

	property p_mod_valid;
		@(posedge i_mclk) disable iff (!i_resetn)
		wr_filt && (i_req.wdata[6:4] == 3'h2) |=> !o_mod_valid;
	endproperty
	a_mod_valid: assert property (p_mod_valid) else $error("unassigned code accepted");

	property p_manch;
		@(posedge i_mclk) disable iff (!i_resetn)
		wr_filt |=> o_cfg.manchester_enable == $past(i_req.wdata[3]);
	endproperty
	a_manch: assert property (p_manch) else $error("manchester bit wrong");

	property p_readback;
		@(posedge i_mclk) disable iff (!i_resetn)
		i_req.rd_en && !i_req.wr_en && (i_req.addr == `MCR_OFS_RATE_MANT)
			|=> o_rd_valid && o_rdata == cfg_reg.symbol_rate_mantissa;
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");

	c_bypass: cover property (@(posedge i_mclk) disable iff (!i_resetn)
		wr_filt && i_req.wdata[7] ##1 !o_dc_block_enable);
	c_tick: cover property (@(posedge i_mclk) disable iff (!i_resetn) o_symbol_tick);
	c_ook: cover property (@(posedge i_mclk) disable iff (!i_resetn)
		o_cfg.modulation_select == 3'h3);
	c_read_exp: cover property (@(posedge i_mclk) disable iff (!i_resetn)
		i_req.rd_en && i_req.addr == `MCR_OFS_BW_RATE_EXP ##1 o_rd_valid);

endmodule
`default_nettype wire

//--- rtl/mcr_pkg.sv
/*
 Types of the modem configuration bank.
 Assumes the constants header is on the include path.
*/
`default_nettype none
`include "mcr_regs.svh"

package mcr_pkg;

	typedef enum logic [2:0] {
		MCR_MOD_2FSK = 3'h0,
		MCR_MOD_GFSK = 3'h1,
		MCR_MOD_OOK = 3'h3,
		MCR_MOD_MSK = 3'h7
	} mcr_mod_e;

	typedef struct packed {
		logic [1:0] bandwidth_exponent;
		logic [1:0] bandwidth_mantissa;
		logic [3:0] symbol_rate_exponent;
		logic [7:0] symbol_rate_mantissa;
		logic dc_block_bypass;
		logic [2:0] modulation_select;
		logic manchester_enable;
	} mcr_cfg_s;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [`MCR_ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} mcr_req_s;

endpackage
`default_nettype wire

//--- rtl/mcr_regs.svh
/*
 Offsets, field positions and reset values of the modem configuration bank.
 Assumes inclusion by bare name from the package and the bank module.
*/
`ifndef MCR_REGS_SVH
`define MCR_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define MCR_ADDR_W 6
`define MCR_OFS_BW_RATE_EXP 6'h10
`define MCR_OFS_RATE_MANT 6'h11
`define MCR_OFS_FILT_MOD 6'h12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MCR_BW_EXP_HI 7
`define MCR_BW_EXP_LO 6
`define MCR_BW_MANT_HI 5
`define MCR_BW_MANT_LO 4
`define MCR_RATE_EXP_HI 3
`define MCR_RATE_EXP_LO 0
`define MCR_DC_BYPASS_BIT 7
`define MCR_MOD_HI 6
`define MCR_MOD_LO 4
`define MCR_MANCH_BIT 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MCR_RST_BW_EXP 2'h2
`define MCR_RST_BW_MANT 2'h0
`define MCR_RST_RATE_EXP 4'hc
`define MCR_RST_RATE_MANT 8'h22
`define MCR_RST_DC_BYPASS 1'h0
`define MCR_RST_MOD 3'h0
`define MCR_RST_MANCH 1'h0
// 8 * (4 + 0) * 2^2 for the reset bandwidth fields
`define MCR_RST_DECIM 9'h080

// ----------------------------------------
// Arithmetic constants
// ----------------------------------------
`define MCR_BW_MANT_OFFSET 3'h4
`define MCR_BW_DIV_SHIFT 4'h3
`define MCR_RATE_HIDDEN_ONE 1'h1
`define MCR_RATE_ACC_W 28

`endif

//--- verif/mcr_host.sv
/*
 Host model issuing decoded register requests to the bank.
 Assumes single-cycle requests sampled on the bank clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mcr_regs.svh"
module mcr_host (
	input wire logic i_mclk,
	output var mcr_pkg::mcr_req_s o_req,
	input wire logic [7:0] i_rdata,
	input wire logic i_rd_valid
);
	initial o_req = '0;
	// ----------------------------------------
	// Transfer
	// ----------------------------------------
	task automatic xfer(input logic w, input logic r, input logic [5:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic v);
		@(posedge i_mclk);
		o_req <= '{wr_en: w, rd_en: r, addr: a, wdata: d};
		@(posedge i_mclk);
		o_req <= '0;
		#1;
		q = i_rdata;
		v = i_rd_valid;
		if (w && a == `MCR_OFS_FILT_MOD && d[7]) begin
			@(posedge i_mclk);
			o_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: 6'h0b, wdata: 8'h0f};
			@(posedge i_mclk);
			o_req <= '0;
			#1;
		end
	endtask
endmodule
`default_nettype wire

//--- verif/tb_modem_config_regs.sv
/*
 Self-checking bench of the modem configuration bank.
 Assumes the bank and its host model from the verification folder.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_modem_config_regs;
	typedef struct {logic [5:0] a; logic [7:0] d; logic [7:0] rb;} mcr_row_s;
	logic i_mclk;
	logic i_resetn = 1'b0;
	mcr_pkg::mcr_req_s req;
	mcr_pkg::mcr_cfg_s cfg;
	logic [7:0] rdata;
	logic [7:0] q;
	logic [8:0] dec;
	logic rd_valid, tick, dc_en, mod_ok, v;
	int errors = 0;
	int check_count = 0;
	int n;
	mcr_row_s rows [0:7];
	mcr_bank u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_req(req), .o_rdata(rdata),
		.o_rd_valid(rd_valid), .o_cfg(cfg), .o_decimation(dec), .o_symbol_tick(tick),
		.o_dc_block_enable(dc_en), .o_mod_valid(mod_ok));
	mcr_host u_host (.i_mclk(i_mclk), .o_req(req), .i_rdata(rdata), .i_rd_valid(rd_valid));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic do_reset(input int c);
		@(posedge i_mclk);
		i_resetn <= 1'b0;
		repeat (c) @(posedge i_mclk);
		i_resetn <= 1'b1;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		u_host.xfer(1'b0, 1'b1, a, 8'h00, q, v);
		chk("rd_valid", 1, v);
		chk("rdata", e, q);
	endtask
	task automatic reset_check;
		rd(6'h10, 8'h8c);
		rd(6'h11, 8'h22);
		rd(6'h12, 8'h00);
		chk("decimation", 8 * 4 * 4, dec);
		chk("dc_enable", 1, dc_en);
		chk("mod_select", 0, cfg.modulation_select);
	endtask
	// Ticks are periodic only once the accumulator has wrapped once
	task automatic tick_period(output int p);
		int k;
		k = 0;
		// Skip a tick still launched with the old rate
		@(posedge i_mclk);
		#1;
		while (tick !== 1'b1 && k < 300) begin
			@(posedge i_mclk);
			#1;
			k++;
		end
		p = 0;
		do begin
			@(posedge i_mclk);
			#1;
			p++;
		end while (tick !== 1'b1 && p < 300);
	endtask
	// ----------------------------------------
	// Clock, watchdog, sequence
	// ----------------------------------------
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	initial begin
		#100000;
		errors++;
		test_done;
	end
	initial begin
		rows = '{'{6'h10, 8'h00, 8'h00}, '{6'h10, 8'hff, 8'hff}, '{6'h10, 8'h5a, 8'h5a},
			'{6'h11, 8'ha5, 8'ha5}, '{6'h12, 8'hff, 8'hf8}, '{6'h12, 8'h38, 8'h38},
			'{6'h20, 8'h55, 8'h00}, '{6'h3f, 8'hff, 8'h00}};
		do_reset(12);
		reset_check;
		foreach (rows[i]) begin
			u_host.xfer(1'b1, 1'b0, rows[i].a, rows[i].d, q, v);
			@(posedge i_mclk);
			#1;
			if (rows[i].a == 6'h10)
				chk("decimation", 32'((8 * (4 + rows[i].d[5:4])) << rows[i].d[7:6]), dec);
			if (rows[i].a == 6'h12)
				chk("dc_enable", !rows[i].d[7], dc_en);
			rd(rows[i].a, rows[i].rb);
		end
		// Read and write together see the old value
		u_host.xfer(1'b1, 1'b1, 6'h11, 8'h77, q, v);
		chk("rdata_old", 8'ha5, q);
		rd(6'h11, 8'h77);
		for (int c = 0; c < 8; c++) begin
			u_host.xfer(1'b1, 1'b0, 6'h12, {1'b0, 3'(c), 4'h8}, q, v);
			chk("mod_valid", (c == 0 || c == 1 || c == 3 || c == 7), mod_ok);
			chk("manchester", 1, cfg.manchester_enable);
		end
		u_host.xfer(1'b1, 1'b0, 6'h11, 8'h00, q, v);
		for (int e = 15; e > 13; e--) begin
			u_host.xfer(1'b1, 1'b0, 6'h10, 8'(e), q, v);
			tick_period(n);
			chk("tick_period", 32'(1 << (20 - e)), n);
		end
		u_host.xfer(1'b1, 1'b0, 6'h11, 8'hff, q, v);
		chk("rate_mant", 8'hff, cfg.symbol_rate_mantissa);
		do_reset(2);
		reset_check;
		test_done;
	end
endmodule
`default_nettype wire
